// file: hw/fcor_pkg.sv
// Package for the flash clock divider and option register block.
// Assumes an APB slave with 32-bit data on a 25 MHz bus clock.
package fcor_pkg;
    localparam logic [11:0] FCOR_DIV_OFFSET  = 12'h000;
    localparam logic [11:0] FCOR_OPT_OFFSET  = 12'h004;
    localparam logic [11:0] FCOR_STAT_OFFSET = 12'h008;
    localparam logic [11:0] FCOR_KEY_OFFSET  = 12'h00c;
    localparam logic [11:0] FCOR_KCTL_OFFSET = 12'h010;
    localparam logic [11:0] FCOR_BLNK_OFFSET = 12'h014;
    localparam logic [11:0] FCOR_MEM_OFFSET  = 12'h100;
    localparam int          FCOR_FLAG_BIT    = 7;
    localparam int          FCOR_PRE_BIT     = 6;
    localparam int          FCOR_BACKDOOR_ENABLE_BIT   = 7;
    localparam int          FCOR_NORED_BIT   = 6;
    localparam logic [7:0]  FCOR_DIV_RESET   = 8'h00;
    localparam logic [7:0]  FCOR_OPT_MASK    = 8'hc3;
    localparam logic [1:0]  FCOR_UNSECURED   = 2'h2;
    localparam logic [2:0]  FCOR_PRESCALE_MAX = 3'h7;
    localparam int          FCOR_KEY_BYTES   = 8;

    typedef struct packed {
        logic       backdoor_enable;
        logic       redirect_disable;
        logic [1:0] lock_state_code;
    } fcor_option_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fcor_apb_req_type;
endpackage

// file: hw/fcor_top.sv
// Flash clock divider, option mirror and security gate.
// Assumes an APB master on pclk and a nonvolatile option byte stable at reset release.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fcor_top
    import fcor_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire fcor_pkg::fcor_apb_req_type apb_req,
    input  wire logic                  psecure,
    input  wire logic [7:0]            option_nonvolatile_byte,
    input  wire logic [63:0]           stored_unlock_key,
    input  wire logic                  op_request,
    input  wire logic                  blank_found,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       nvm_timing_clock,
    output logic                       op_accept,
    output logic                       op_refuse,
    output logic                       redirect_disable,
    output logic                       device_secured
);
    import fcor_pkg::*;

    logic             setup;
    logic             access_q;
    logic             wr_en;
    logic             rd_en;
    logic [11:0]      addr;
    logic             mapped;
    logic             flag_q;
    logic [6:0]       div_q;
    logic             opt_loaded_q;
    fcor_option_type  opt_q;
    logic [2:0]       pre_q;
    logic [5:0]       ratio_q;
    logic             pre_tick;
    logic             key_mode_q;
    logic [3:0]       key_idx_q;
    logic             key_ok_q;
    logic             blank_q;
    logic             blank_s_q;
    logic             blank_s2_q;
    logic             key_ctl_wr;
    logic             key_byte_wr;
    logic             key_byte_ok;
    logic             ratio_wrap;
    logic [7:0]       mem_q;
    logic [7:0]       opt_view;
    logic [31:0]      rdata_d;

    assign setup  = apb_req.psel && !apb_req.penable;
    assign addr   = apb_req.paddr;
    assign wr_en  = apb_req.psel && apb_req.penable && apb_req.pwrite && access_q;
    assign rd_en  = setup && !apb_req.pwrite;

    // Address decode for the seven mapped word offsets.
    always_comb
    begin
        mapped = 1'b0;
        case (addr)
            FCOR_DIV_OFFSET:  mapped = 1'b1;
            FCOR_OPT_OFFSET:  mapped = 1'b1;
            FCOR_STAT_OFFSET: mapped = 1'b1;
            FCOR_KEY_OFFSET:  mapped = 1'b1;
            FCOR_KCTL_OFFSET: mapped = 1'b1;
            FCOR_BLNK_OFFSET: mapped = 1'b1;
            FCOR_MEM_OFFSET:  mapped = 1'b1;
            default:          mapped = 1'b0;
        endcase
    end

    // Key strobes accept only writes from secure firmware.
    assign key_ctl_wr  = wr_en && (addr == FCOR_KCTL_OFFSET) && psecure;
    assign key_byte_wr = wr_en && (addr == FCOR_KEY_OFFSET) && psecure && key_mode_q;
    assign key_byte_ok = (key_idx_q < 4'(FCOR_KEY_BYTES)) &&
                         (apb_req.pwdata[7:0] == stored_unlock_key[key_idx_q[2:0]*8 +: 8]);
    assign ratio_wrap  = ratio_q >= div_q[5:0];

    // Slave answers in the first access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            access_q <= 1'b0;
        else
            access_q <= setup;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= setup && !mapped;
        end
    end

    // Divider register: flag set by first write, value latched once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= FCOR_DIV_RESET[FCOR_FLAG_BIT];
            div_q  <= FCOR_DIV_RESET[6:0];
        end
        else if (wr_en && addr == FCOR_DIV_OFFSET && !flag_q)
        begin
            flag_q <= 1'b1;
            div_q  <= apb_req.pwdata[6:0];
        end
    end

    // Option byte is captured in the first clock after reset release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt_loaded_q <= 1'b0;
        end
        else
        begin
            opt_loaded_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt_q <= '0;
        end
        else if (!opt_loaded_q)
        begin
            opt_q.backdoor_enable  <= option_nonvolatile_byte[FCOR_BACKDOOR_ENABLE_BIT];
            opt_q.redirect_disable <= option_nonvolatile_byte[FCOR_NORED_BIT];
            opt_q.lock_state_code  <= option_nonvolatile_byte[1:0];
        end
        else if (key_ok_q || blank_q)
        begin
            opt_q.lock_state_code <= FCOR_UNSECURED;
        end
    end

    // Read-only view; unused bits are zero and writes are ignored.
    assign opt_view = {opt_q.backdoor_enable, opt_q.redirect_disable, 4'h0,
                       opt_q.lock_state_code} & FCOR_OPT_MASK;

    // Prescaler and ratio counters produce a one-cycle timing pulse.
    assign pre_tick = !div_q[FCOR_PRE_BIT] || (pre_q == FCOR_PRESCALE_MAX);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= '0;
        end
        else if (div_q[FCOR_PRE_BIT])
        begin
            pre_q <= pre_q + 3'h1;
        end
        else
        begin
            pre_q <= 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ratio_q <= '0;
        end
        else if (pre_tick && ratio_wrap)
        begin
            ratio_q <= 6'h00;
        end
        else if (pre_tick)
        begin
            ratio_q <= ratio_q + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nvm_timing_clock <= 1'b0;
        end
        else
        begin
            nvm_timing_clock <= pre_tick && ratio_wrap && flag_q;
        end
    end

    // Program and erase requests are gated by the divisor flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_accept <= 1'b0;
        end
        else
        begin
            op_accept <= op_request && flag_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_refuse <= 1'b0;
        end
        else
        begin
            op_refuse <= op_request && !flag_q;
        end
    end

    // Backdoor key sequence: eight ordered byte writes from secure firmware.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_mode_q <= 1'b0;
        end
        else if (key_ctl_wr)
        begin
            key_mode_q <= apb_req.pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_idx_q <= '0;
        end
        else if (key_ctl_wr && apb_req.pwdata[0])
        begin
            key_idx_q <= '0;
        end
        else if (key_byte_wr && key_byte_ok)
        begin
            key_idx_q <= key_idx_q + 4'h1;
        end
        else if (key_byte_wr)
        begin
            key_idx_q <= 4'hf;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_ok_q <= 1'b0;
        end
        else
        begin
            key_ok_q <= key_ctl_wr && !apb_req.pwdata[0] && key_mode_q &&
                        opt_q.backdoor_enable &&
                        (key_idx_q == 4'(FCOR_KEY_BYTES));
        end
    end

    // Blank check pulse from the array passes two flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blank_s_q  <= 1'b0;
            blank_s2_q <= 1'b0;
        end
        else
        begin
            blank_s_q  <= blank_found;
            blank_s2_q <= blank_s_q;
        end
    end

    // Software hook for a passed blank check.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blank_q <= 1'b0;
        end
        else
        begin
            blank_q <= blank_s2_q || (wr_en && addr == FCOR_BLNK_OFFSET && psecure
                       && apb_req.pwdata[0]);
        end
    end

    // Secure memory byte: blocked writes are dropped.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_q <= '0;
        else if (wr_en && addr == FCOR_MEM_OFFSET && (psecure || !device_secured))
            mem_q <= apb_req.pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            redirect_disable <= 1'b0;
        end
        else
        begin
            redirect_disable <= opt_q.redirect_disable;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            device_secured <= 1'b1;
        end
        else
        begin
            device_secured <= opt_q.lock_state_code != FCOR_UNSECURED;
        end
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (addr)
            FCOR_DIV_OFFSET:  rdata_d = {24'h0, flag_q, div_q};
            FCOR_OPT_OFFSET:  rdata_d = {24'h0, opt_view};
            FCOR_STAT_OFFSET: rdata_d = {28'h0, key_mode_q, op_refuse, device_secured, flag_q};
            FCOR_KCTL_OFFSET: rdata_d = {31'h0, key_mode_q};
            FCOR_MEM_OFFSET:  rdata_d = (psecure || !device_secured) ?
                                        {24'h0, mem_q} : 32'h0000_0000;
            default:          rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (rd_en)
            prdata <= rdata_d;
    end
endmodule
`default_nettype wire

// file: verif/fcor_asserts.sv
// Concurrent checks for the flash clock and option block.
// Bound to fcor_top by the bench; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module fcor_asserts
    import fcor_pkg::*;
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire fcor_pkg::fcor_apb_req_type apb_req,
    input wire logic                       psecure,
    input wire logic [7:0]                 option_nonvolatile_byte,
    input wire logic                       op_request,
    input wire logic                       blank_found,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       nvm_timing_clock,
    input wire logic                       op_accept,
    input wire logic                       op_refuse,
    input wire logic                       redirect_disable,
    input wire logic                       device_secured
);
    logic       wr_q;
    logic [6:0] div_q;
    logic [1:0] cnt_q;
    wire        rd = apb_req.psel && apb_req.penable && pready && !apb_req.pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_q  <= 1'b0;
            div_q <= 7'h00;
            cnt_q <= 2'h0;
        end
        else
        begin
            cnt_q <= (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
            if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite
                && apb_req.paddr == FCOR_DIV_OFFSET && !wr_q)
            begin
                wr_q  <= 1'b1;
                div_q <= apb_req.pwdata[6:0];
            end
        end
    end
    a_setup_ready: assert property (apb_req.psel && !apb_req.penable |=> pready)
        else $error("no answer after setup");
    a_unmapped_err: assert property (apb_req.psel && !apb_req.penable
        && apb_req.paddr == 12'h020 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_div_read: assert property (rd && apb_req.paddr == FCOR_DIV_OFFSET
        |-> prdata == {24'h0, wr_q, div_q})
        else $error("divider read wrong");
    a_opt_read: assert property (rd && apb_req.paddr == FCOR_OPT_OFFSET
        |-> prdata[31:8] == 24'h0 && prdata[5:2] == 4'h0
        && prdata[7:6] == option_nonvolatile_byte[7:6])
        else $error("option read wrong");
    a_mem_blocked: assert property (rd && apb_req.paddr == FCOR_MEM_OFFSET
        && !psecure && device_secured |-> prdata == 32'h0)
        else $error("blocked read not zero");
    a_op_refused: assert property (op_request && !wr_q |=> op_refuse && !op_accept)
        else $error("operation not refused");
    a_op_allowed: assert property (op_request && wr_q |=> op_accept && !op_refuse)
        else $error("operation not accepted");
    a_no_early_tick: assert property (!wr_q |-> !nvm_timing_clock)
        else $error("timing pulse before divider written");
    a_redirect_bit: assert property (cnt_q == 2'h3
        |-> redirect_disable == option_nonvolatile_byte[6])
        else $error("redirect output wrong");
    a_secure_sticky: assert property (!$rose(device_secured))
        else $error("security engaged without reset");
    a_blank_unlock: assert property (blank_found |-> ##[1:5] !device_secured)
        else $error("blank check did not unsecure");
endmodule
`default_nettype wire

// file: verif/test_flash_clock_and_option_regs.sv
// Self-checking bench for the flash clock and option block.
// Drives fcor_top over APB at 25 MHz; the checker is bound below.
`timescale 1ns/100ps
`default_nettype none
module test_flash_clock_and_option_regs;
    import fcor_pkg::*;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    fcor_apb_req_type req = '0;
    logic             psec = 1'b1;
    logic             op_req = 1'b0;
    logic             blank = 1'b0;
    logic [7:0]       nvb = 8'h83;
    logic [63:0]      key = 64'h0123456789abcdef;
    logic [31:0]      prdata, rd;
    logic             pready, pslverr, tck, op_acc, op_ref, redir, sec, er;
    int               err_count = 0;
    int               checked = 0;
    always #20 pclk = ~pclk;
    fcor_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .psecure(psec),
        .option_nonvolatile_byte(nvb), .stored_unlock_key(key), .op_request(op_req),
        .blank_found(blank), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nvm_timing_clock(tck), .op_accept(op_acc), .op_refuse(op_ref),
        .redirect_disable(redir), .device_secured(sec));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic s);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        psec <= s;
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) err_count++;
        rd = prdata;
        er = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rst(input logic [7:0] o);
        presetn <= 1'b0;
        nvb <= o;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    task automatic op(input logic ok);
        @(posedge pclk);
        op_req <= 1'b1;
        @(posedge pclk);
        op_req <= 1'b0;
        @(negedge pclk);
        chk("accept", op_acc, ok);
        chk("refuse", op_ref, !ok);
    endtask
    task automatic key_in(input logic s);
        apb(1'b1, FCOR_KCTL_OFFSET, 32'h1, s);
        for (int i = 0; i < 8; i++) apb(1'b1, FCOR_KEY_OFFSET, {24'h0, key[8*i +: 8]}, s);
        apb(1'b1, FCOR_KCTL_OFFSET, 32'h0, s);
        repeat (4) @(negedge pclk);
    endtask
    task automatic t_div();
        logic [7:0] dv[2] = '{8'h03, 8'h41};
        int         pv[2] = '{4, 16};
        int         n;
        for (int i = 0; i < 2; i++)
        begin
            rst(8'h83);
            apb(1'b0, FCOR_DIV_OFFSET, 32'h0, 1'b1);
            chk("div reset", rd, 32'h0);
            op(1'b0);
            apb(1'b1, FCOR_DIV_OFFSET, {24'h0, dv[i]}, 1'b1);
            apb(1'b1, FCOR_DIV_OFFSET, 32'h3f, 1'b1);
            apb(1'b0, FCOR_DIV_OFFSET, 32'h0, 1'b1);
            chk("div", rd, {24'h0, 1'b1, dv[i][6:0]});
            n = 0;
            while (tck !== 1'b1 && n < 200) begin @(negedge pclk); n++; end
            n = 0;
            do begin @(negedge pclk); n++; end while (tck !== 1'b1 && n < 200);
            chk("period", n, pv[i]);
            op(1'b1);
        end
        $display("divider test done");
    endtask
    task automatic t_opt();
        logic [7:0] o;
        for (int i = 0; i < 4; i++)
        begin
            o = {i[0], i[1], 4'hf, i[1:0]};
            rst(o);
            apb(1'b1, FCOR_OPT_OFFSET, 32'h0, 1'b1);
            apb(1'b0, FCOR_OPT_OFFSET, 32'h0, 1'b1);
            chk("option", rd, {24'h0, o & 8'hc3});
            chk("redirect", redir, o[6]);
            chk("secured", sec, o[1:0] != 2'b10);
            apb(1'b0, 12'h020, 32'h0, 1'b1);
            chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        end
        $display("option test done");
    endtask
    task automatic t_sec();
        rst(8'h83);
        apb(1'b1, FCOR_MEM_OFFSET, 32'h5a, 1'b1);
        apb(1'b1, FCOR_MEM_OFFSET, 32'ha5, 1'b0);
        apb(1'b0, FCOR_MEM_OFFSET, 32'h0, 1'b0);
        chk("blocked read", rd, 32'h0);
        apb(1'b0, FCOR_MEM_OFFSET, 32'h0, 1'b1);
        chk("dropped write", rd, 32'h5a);
        key_in(1'b0);
        chk("debug key", sec, 1'b1);
        key_in(1'b1);
        chk("key unlock", sec, 1'b0);
        apb(1'b0, FCOR_MEM_OFFSET, 32'h0, 1'b0);
        chk("open read", rd, 32'h5a);
        rst(8'h03);
        key_in(1'b1);
        chk("key disabled", sec, 1'b1);
        @(posedge pclk);
        blank <= 1'b1;
        @(posedge pclk);
        blank <= 1'b0;
        repeat (6) @(negedge pclk);
        chk("blank unlock", sec, 1'b0);
        $display("security test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        t_div();
        t_opt();
        t_sec();
        results();
    end
    initial
    begin
        #200000;
        err_count++;
        results();
    end
endmodule
bind fcor_top fcor_asserts u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .psecure(psecure), .option_nonvolatile_byte(option_nonvolatile_byte),
    .op_request(op_request), .blank_found(blank_found), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nvm_timing_clock(nvm_timing_clock), .op_accept(op_accept),
    .op_refuse(op_refuse), .redirect_disable(redirect_disable),
    .device_secured(device_secured));
`default_nettype wire
